// [hdl/spmc_regs.svh]
// Constants for the scan pin mode control block.
`ifndef SPMC_REGS_SVH
`define SPMC_REGS_SVH

// Width of the pin synchroniser vector and the slot of each pin in it.
`define SPMC_SYNC_W 5
`define SPMC_SYNC_TCK 0
`define SPMC_SYNC_TMS 1
`define SPMC_SYNC_TDI 2
`define SPMC_SYNC_TDO 3
`define SPMC_SYNC_TRST 4

// Reset value of the synchroniser; pulled-up pins read high, TCK idles low.
// A high TCK reset value would show a false rise on the first edge after reset.
`define SPMC_SYNC_RST 5'h1E

// Width of the encoded TAP state.
`define SPMC_STATE_W 4

// Levels used for pins and enables.
`define SPMC_LO 1'b0
`define SPMC_HI 1'b1

`endif

// [hdl/spmc_pkg.sv]
// Types shared by the scan pin mode control block.
package spmc_pkg;

  // TAP controller states, Gray coded along the data and instruction paths.
  typedef enum logic [3:0] {
    SPMC_TLR = 4'h0,
    SPMC_RTI = 4'h1,
    SPMC_SEL_DR = 4'h3,
    SPMC_CAP_DR = 4'h2,
    SPMC_SH_DR = 4'h6,
    SPMC_EX1_DR = 4'h7,
    SPMC_PAU_DR = 4'h5,
    SPMC_EX2_DR = 4'h4,
    SPMC_UPD_DR = 4'hC,
    SPMC_SEL_IR = 4'hD,
    SPMC_CAP_IR = 4'hF,
    SPMC_SH_IR = 4'hE,
    SPMC_EX1_IR = 4'hA,
    SPMC_PAU_IR = 4'hB,
    SPMC_EX2_IR = 4'h9,
    SPMC_UPD_IR = 4'h8
  } spmc_state_t;

endpackage

// [hdl/spmc_tap.sv]
// Sixteen-state TAP controller stepped by sampled TCK rising edges.
`timescale 1ns/1ps
`default_nettype none

module spmc_tap (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic force_tlr_i,
  input wire logic tck_rise_i,
  input wire logic tms_i,
  output var spmc_pkg::spmc_state_t state_o
);

  spmc_pkg::spmc_state_t next_state;
  spmc_pkg::spmc_state_t stepped;

  // (R14) Standard transition diagram.
  always_comb begin
    stepped = state_o;
    unique case (state_o)
      spmc_pkg::SPMC_TLR: stepped = tms_i ? spmc_pkg::SPMC_TLR : spmc_pkg::SPMC_RTI;
      spmc_pkg::SPMC_RTI: stepped = tms_i ? spmc_pkg::SPMC_SEL_DR : spmc_pkg::SPMC_RTI;
      spmc_pkg::SPMC_SEL_DR: stepped = tms_i ? spmc_pkg::SPMC_SEL_IR : spmc_pkg::SPMC_CAP_DR;
      spmc_pkg::SPMC_CAP_DR: stepped = tms_i ? spmc_pkg::SPMC_EX1_DR : spmc_pkg::SPMC_SH_DR;
      spmc_pkg::SPMC_SH_DR: stepped = tms_i ? spmc_pkg::SPMC_EX1_DR : spmc_pkg::SPMC_SH_DR;
      spmc_pkg::SPMC_EX1_DR: stepped = tms_i ? spmc_pkg::SPMC_UPD_DR : spmc_pkg::SPMC_PAU_DR;
      spmc_pkg::SPMC_PAU_DR: stepped = tms_i ? spmc_pkg::SPMC_EX2_DR : spmc_pkg::SPMC_PAU_DR;
      spmc_pkg::SPMC_EX2_DR: stepped = tms_i ? spmc_pkg::SPMC_UPD_DR : spmc_pkg::SPMC_SH_DR;
      spmc_pkg::SPMC_UPD_DR: stepped = tms_i ? spmc_pkg::SPMC_SEL_DR : spmc_pkg::SPMC_RTI;
      spmc_pkg::SPMC_SEL_IR: stepped = tms_i ? spmc_pkg::SPMC_TLR : spmc_pkg::SPMC_CAP_IR;
      spmc_pkg::SPMC_CAP_IR: stepped = tms_i ? spmc_pkg::SPMC_EX1_IR : spmc_pkg::SPMC_SH_IR;
      spmc_pkg::SPMC_SH_IR: stepped = tms_i ? spmc_pkg::SPMC_EX1_IR : spmc_pkg::SPMC_SH_IR;
      spmc_pkg::SPMC_EX1_IR: stepped = tms_i ? spmc_pkg::SPMC_UPD_IR : spmc_pkg::SPMC_PAU_IR;
      spmc_pkg::SPMC_PAU_IR: stepped = tms_i ? spmc_pkg::SPMC_EX2_IR : spmc_pkg::SPMC_PAU_IR;
      spmc_pkg::SPMC_EX2_IR: stepped = tms_i ? spmc_pkg::SPMC_UPD_IR : spmc_pkg::SPMC_SH_IR;
      spmc_pkg::SPMC_UPD_IR: stepped = tms_i ? spmc_pkg::SPMC_SEL_DR : spmc_pkg::SPMC_RTI;
    endcase
  end

  // The state only moves on a sampled TCK rise; a forced reset overrides it.
  always_comb begin
    next_state = state_o;
    if (force_tlr_i) begin
      next_state = spmc_pkg::SPMC_TLR;
    end else if (tck_rise_i) begin
      next_state = stepped;
    end
  end

  // (R5) Reset enters Test-Logic-Reset.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_o <= spmc_pkg::SPMC_TLR;
    end else begin
      state_o <= next_state;
    end
  end

endmodule

`default_nettype wire

// [hdl/spmc_top.sv]
// Scan pin mode control: hands TDI, TCK, TDO and TRST to user logic or the scan port.
// What this block does
// (R1) Dedicated mode keeps user logic off scan pins.
// (R2) Dedicated mode enables TMS and TDI pull-ups.
// (R3) Flexible mode: pins shared, chosen by TAP state.
// (R4) Flexible mode applies no TMS, TDI pull-ups.
// (R5) TAP starts in Test-Logic-Reset after reset.
// (R6) Test-Logic-Reset in flexible mode gives pins to user logic.
// (R7) TCK rise with TMS low claims pins.
// (R8) Tester holds TMS high five cycles to release.
// (R9) Reserved TRST is scan reset with pull-up.
// (R10) Board holds TRST low in normal operation.
// (R11) Unreserved TRST is user I/O, else tristated.
// (R12) TMS is never user I/O.
// (R13) Select muxes input, output and enable per pin.
// (R14) TAP follows standard sixteen-state diagram.
`timescale 1ns/1ps
`default_nettype none

`include "spmc_regs.svh"

module spmc_top (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Configuration straps, caught while reset is held.
  input wire logic cfg_dedicated_i,
  input wire logic cfg_trst_reserved_i,
  // Scan pins as seen at the pads.
  input wire logic tck_pin_i,
  output logic tck_pin_o,
  output logic tck_pin_oe_o,
  input wire logic tms_pin_i,
  input wire logic tdi_pin_i,
  output logic tdi_pin_o,
  output logic tdi_pin_oe_o,
  input wire logic tdo_pin_i,
  output logic tdo_pin_o,
  output logic tdo_pin_oe_o,
  input wire logic trst_pin_i,
  output logic trst_pin_o,
  output logic trst_pin_oe_o,
  // Internal pull-up enables.
  output logic tms_pullup_o,
  output logic tdi_pullup_o,
  output logic trst_pullup_o,
  // User logic side of the shared pins.
  output logic user_tck_o,
  input wire logic user_tck_i,
  input wire logic user_tck_oe_i,
  output logic user_tdi_o,
  input wire logic user_tdi_i,
  input wire logic user_tdi_oe_i,
  output logic user_tdo_o,
  input wire logic user_tdo_i,
  input wire logic user_tdo_oe_i,
  output logic user_trst_o,
  input wire logic user_trst_used_i,
  input wire logic user_trst_i,
  input wire logic user_trst_oe_i,
  // Scan port side.
  input wire logic scan_tdo_i,
  output logic scan_tdi_o,
  output logic scan_tck_rise_o,
  output logic scan_tck_fall_o,
  output logic scan_owns_o,
  output var spmc_pkg::spmc_state_t tap_state_o
);

  logic [`SPMC_SYNC_W-1:0] sync_meta;
  logic [`SPMC_SYNC_W-1:0] sync_pins;
  logic tck_prev;
  logic dedicated;
  logic trst_reserved;
  logic tdo_shift;
  spmc_pkg::spmc_state_t tap_state;

  wire logic [`SPMC_SYNC_W-1:0] raw_pins = {trst_pin_i, tdo_pin_i, tdi_pin_i, tms_pin_i, tck_pin_i};
  wire logic s_tck = sync_pins[`SPMC_SYNC_TCK];
  wire logic s_tms = sync_pins[`SPMC_SYNC_TMS];
  wire logic s_tdi = sync_pins[`SPMC_SYNC_TDI];
  wire logic s_tdo = sync_pins[`SPMC_SYNC_TDO];
  wire logic s_trst = sync_pins[`SPMC_SYNC_TRST];

  // Every pin passes two flops; only the second stage is read anywhere.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sync_meta <= `SPMC_SYNC_RST;
      sync_pins <= `SPMC_SYNC_RST;
    end else begin
      sync_meta <= raw_pins;
      sync_pins <= sync_meta;
    end
  end

  // Straps are sampled while reset is held, so a mode change needs a fresh reset.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      dedicated <= cfg_dedicated_i;
      trst_reserved <= cfg_trst_reserved_i;
    end
  end

  // TCK edge detection on the synchronised level; TCK must stay well below ref_clk/4.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tck_prev <= `SPMC_LO;
    end else begin
      tck_prev <= s_tck;
    end
  end

  wire logic tck_rise = s_tck & ~tck_prev;
  wire logic tck_fall = ~s_tck & tck_prev;

  // (R9) Reserved TRST low holds the controller in Test-Logic-Reset.
  wire logic force_tlr = trst_reserved & ~s_trst;

  // (R7) TMS low at TCK rise moves the controller out of Test-Logic-Reset.
  // (R8) Five TMS-high rises always walk back to Test-Logic-Reset.
  // (R12) TMS feeds only the controller.
  spmc_tap u_tap (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .force_tlr_i(force_tlr),
    .tck_rise_i(tck_rise),
    .tms_i(s_tms),
    .state_o(tap_state)
  );

  // (R13) Ownership select from mode and state.
  // (R6) Test-Logic-Reset in flexible mode gives pins to user logic.
  wire logic owns = dedicated | (tap_state != spmc_pkg::SPMC_TLR);

  // While the scan port owns the pins, TDO drives only while shifting, as a scan output should.
  wire logic shifting = (tap_state == spmc_pkg::SPMC_SH_DR) |
                        (tap_state == spmc_pkg::SPMC_SH_IR);

  // Scan TDO data changes on the falling TCK edge to give the tester a full half period.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tdo_shift <= `SPMC_LO;
    end else if (tck_fall) begin
      tdo_shift <= scan_tdo_i;
    end
  end

  // (R1) User paths are cut whenever the scan port owns the pins.
  // (R3) Each shared pin muxes input, output value and enable.
  wire logic next_tck_oe = owns ? `SPMC_LO : user_tck_oe_i;
  wire logic next_tck_o = owns ? `SPMC_LO : user_tck_i;
  wire logic next_tdi_oe = owns ? `SPMC_LO : user_tdi_oe_i;
  wire logic next_tdi_o = owns ? `SPMC_LO : user_tdi_i;
  wire logic next_tdo_oe = owns ? shifting : user_tdo_oe_i;
  wire logic next_tdo_o = owns ? tdo_shift : user_tdo_i;
  wire logic next_user_tck = owns ? `SPMC_LO : s_tck;
  wire logic next_user_tdi = owns ? `SPMC_LO : s_tdi;
  wire logic next_user_tdo = owns ? `SPMC_LO : s_tdo;

  // (R11) Unreserved TRST is user I/O; an unused one stays tristated.
  wire logic trst_user = ~trst_reserved;
  wire logic next_trst_oe = trst_user & user_trst_used_i & user_trst_oe_i;
  wire logic next_trst_o = trst_user & user_trst_used_i & user_trst_i;
  wire logic next_user_trst = trst_user & s_trst;

  // (R2) Pull-ups on TMS and TDI only in dedicated mode.
  // (R4) Flexible mode leaves them off.
  wire logic next_pull = dedicated;

  // (R9) Reserved TRST keeps its pull-up on.
  wire logic next_trst_pull = trst_reserved;

  // Registered pad drives; pins settle one ref_clk after ownership changes.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tck_pin_o <= `SPMC_LO;
      tck_pin_oe_o <= `SPMC_LO;
      tdi_pin_o <= `SPMC_LO;
      tdi_pin_oe_o <= `SPMC_LO;
      tdo_pin_o <= `SPMC_LO;
      tdo_pin_oe_o <= `SPMC_LO;
      trst_pin_o <= `SPMC_LO;
      trst_pin_oe_o <= `SPMC_LO;
    end else begin
      tck_pin_o <= next_tck_o;
      tck_pin_oe_o <= next_tck_oe;
      tdi_pin_o <= next_tdi_o;
      tdi_pin_oe_o <= next_tdi_oe;
      tdo_pin_o <= next_tdo_o;
      tdo_pin_oe_o <= next_tdo_oe;
      trst_pin_o <= next_trst_o;
      trst_pin_oe_o <= next_trst_oe;
    end
  end

  // Registered pull-up enables and user-side inputs.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tms_pullup_o <= `SPMC_LO;
      tdi_pullup_o <= `SPMC_LO;
      trst_pullup_o <= `SPMC_LO;
      user_tck_o <= `SPMC_LO;
      user_tdi_o <= `SPMC_LO;
      user_tdo_o <= `SPMC_LO;
      user_trst_o <= `SPMC_LO;
    end else begin
      tms_pullup_o <= next_pull;
      tdi_pullup_o <= next_pull;
      trst_pullup_o <= next_trst_pull;
      user_tck_o <= next_user_tck;
      user_tdi_o <= next_user_tdi;
      user_tdo_o <= next_user_tdo;
      user_trst_o <= next_user_trst;
    end
  end

  // Registered scan-side view; strobes are one ref_clk wide.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      scan_tdi_o <= `SPMC_LO;
      scan_tck_rise_o <= `SPMC_LO;
      scan_tck_fall_o <= `SPMC_LO;
      scan_owns_o <= `SPMC_LO;
      tap_state_o <= spmc_pkg::SPMC_TLR;
    end else begin
      scan_tdi_o <= owns & s_tdi;
      scan_tck_rise_o <= owns & tck_rise;
      scan_tck_fall_o <= owns & tck_fall;
      scan_owns_o <= owns;
      tap_state_o <= tap_state;
    end
  end

endmodule

`default_nettype wire

// [test/spmc_checker.sv]
// Port-level assertions for the scan pin mode control block.
`timescale 1ns/1ps
`default_nettype none
module spmc_checker (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic cfg_dedicated_i,
  input wire logic cfg_trst_reserved_i,
  input wire logic tck_pin_i,
  input wire logic tms_pin_i,
  input wire logic trst_pin_i,
  input wire logic user_trst_used_i,
  input wire logic trst_pin_oe_o,
  input wire logic tms_pullup_o,
  input wire logic tdi_pullup_o,
  input wire logic trst_pullup_o,
  input wire logic user_tck_o,
  input wire logic user_tdi_o,
  input wire logic user_tdo_o,
  input wire logic user_trst_o,
  input wire logic scan_owns_o,
  input wire spmc_pkg::spmc_state_t tap_state_o
);
  logic ded;
  logic tres;
  logic [1:0] up;
  logic ok;
  logic tlr;
  logic go;
  // Straps are caught in reset as the block does; ok marks outputs that have settled.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ded <= cfg_dedicated_i;
      tres <= cfg_trst_reserved_i;
      up <= 2'h0;
    end else if (up != 2'h3) begin
      up <= up + 2'h1;
    end
  end
  // A reserved test reset held low pins the controller, so clock edges then prove nothing.
  assign ok = up == 2'h3;
  assign tlr = tap_state_o == spmc_pkg::SPMC_TLR;
  assign go = ok && (!tres || trst_pin_i);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  property p_rst; $fell(reset_i) |-> tlr; endproperty
  a_rst: assert property (p_rst) else $error("state after reset");
  property p_claim; go && tlr && $rose(tck_pin_i) && !tms_pin_i |-> ##[3:8] !tlr; endproperty
  a_claim: assert property (p_claim) else $error("pins not claimed");
  property p_pull; ok |-> tms_pullup_o == ded && tdi_pullup_o == ded; endproperty
  a_pull: assert property (p_pull) else $error("pull-up mode");
  property p_tpu; ok |-> trst_pullup_o == tres && !(tres && (trst_pin_oe_o || user_trst_o)); endproperty
  a_tpu: assert property (p_tpu) else $error("test reset pin");
  property p_cut; ok && ded |-> !(user_tck_o || user_tdi_o || user_tdo_o); endproperty
  a_cut: assert property (p_cut) else $error("user path open");
  property p_user; ok && !ded && tlr && $past(tlr) |-> !scan_owns_o; endproperty
  a_user: assert property (p_user) else $error("pins kept by scan");
  property p_own; ok && !tlr && !$past(tlr) |-> scan_owns_o && !(user_tck_o || user_tdi_o); endproperty
  a_own: assert property (p_own) else $error("pins not owned");
  property p_free; ok && !tres && !user_trst_used_i && !$past(user_trst_used_i) |-> !trst_pin_oe_o;
  endproperty
  a_free: assert property (p_free) else $error("unused pin driven");
  c_claim: cover property (ok && !ded && scan_owns_o);
  c_shift: cover property (tap_state_o == spmc_pkg::SPMC_SH_DR);
  c_back: cover property ($fell(scan_owns_o));
endmodule
bind spmc_top spmc_checker chk (.*);
`default_nettype wire

// [test/spmc_tester.sv]
// Scan tester model driving the shared scan pins.
`timescale 1ns/1ps
`default_nettype none
module spmc_tester (
  input wire logic ref_clk_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_o
);
  // Clock idles low outside frames; mode select idles high as its board pull-up holds it.
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    trst_o = 1'b0;
  end
  task automatic pins(input logic tdi_v, input logic trst_v);
    @(posedge ref_clk_i);
    tdi_o <= tdi_v;
    trst_o <= trst_v;
  endtask
  // select per rise
  // TCK is high four and low four ref_clk periods, a 160 ns link clock.
  // The closing edge lets the state output settle before the caller looks.
  task automatic step(input logic tms_v);
    @(posedge ref_clk_i);
    tms_o <= tms_v;
    repeat (2) @(posedge ref_clk_i);
    tck_o <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    tck_o <= 1'b0;
    @(posedge ref_clk_i);
  endtask
endmodule
`default_nettype wire

// [test/test_spmc_top.sv]
// Self-checking bench for the scan pin mode control block.
`timescale 1ns/1ps
`default_nettype none
module test_spmc_top;
  logic ref_clk_i, reset_i, cfg_dedicated_i, cfg_trst_reserved_i, tck_pin_i, tms_pin_i;
  logic tdi_pin_i, tdo_pin_i, trst_pin_i, user_tck_i, user_tck_oe_i, user_tdi_i;
  logic user_tdi_oe_i, user_tdo_i, user_tdo_oe_i, user_trst_used_i, user_trst_i;
  logic user_trst_oe_i, scan_tdo_i, tck_pin_o, tck_pin_oe_o, tdi_pin_o, tdi_pin_oe_o;
  logic tdo_pin_o, tdo_pin_oe_o, trst_pin_o, trst_pin_oe_o, tms_pullup_o, tdi_pullup_o;
  logic trst_pullup_o, user_tck_o, user_tdi_o, user_tdo_o, user_trst_o, scan_tdi_o;
  logic scan_tck_rise_o, scan_tck_fall_o, scan_owns_o;
  spmc_pkg::spmc_state_t tap_state_o;
  int failures = 0;
  int samples_checked = 0;
  int user_tck_highs = 0;
  int rise_pulses = 0;
  int fall_pulses = 0;
  // Tallies of levels and strobes; each edge sees the outputs as they stood before it.
  always @(posedge ref_clk_i) begin
    if (user_tck_o === 1'b1) user_tck_highs++;
    if (scan_tck_rise_o === 1'b1) rise_pulses++;
    if (scan_tck_fall_o === 1'b1) fall_pulses++;
  end
  spmc_top dut (.*);
  spmc_tester tester (.ref_clk_i(ref_clk_i), .tck_o(tck_pin_i), .tms_o(tms_pin_i),
    .tdi_o(tdi_pin_i), .trst_o(trst_pin_i));
  // Clock at 50 MHz.
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  // Compares wait a step, but test the values as they stood when the task was called.
  task automatic chk_bit(input logic got, input logic exp);
    #1;
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t bit %b not %b", $time, got, exp);
    end
  endtask
  task automatic chk_state(input spmc_pkg::spmc_state_t got, input spmc_pkg::spmc_state_t exp);
    #1;
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t state %h not %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("Compared %0d, mismatched %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Straps must be steady while reset is held, since they are only caught then.
  task automatic do_reset(input logic ded, input logic tres);
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    cfg_dedicated_i <= ded;
    cfg_trst_reserved_i <= tres;
    repeat (5) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask
  task automatic sc_ded;
    int base_rise;
    int base_fall;
    do_reset(1'b1, 1'b1);
    tester.pins(1'b1, 1'b0);
    repeat (6) @(posedge ref_clk_i);
    chk_bit(tms_pullup_o & tdi_pullup_o & trst_pullup_o, 1'b1);
    chk_bit(user_tdi_o | user_trst_o | trst_pin_oe_o, 1'b0);
    chk_bit(scan_tdi_o, 1'b1);
    tester.step(1'b0);
    chk_state(tap_state_o, spmc_pkg::SPMC_TLR);
    tester.pins(1'b1, 1'b1);
    repeat (4) @(posedge ref_clk_i);
    base_rise = rise_pulses;
    base_fall = fall_pulses;
    tester.step(1'b0);
    chk_state(tap_state_o, spmc_pkg::SPMC_RTI);
    repeat (4) @(posedge ref_clk_i);
    chk_bit(rise_pulses - base_rise == 1 && fall_pulses - base_fall == 1, 1'b1);
  endtask
  task automatic sc_flex;
    int base_tck;
    int base_rise;
    int base_fall;
    do_reset(1'b0, 1'b0);
    chk_state(tap_state_o, spmc_pkg::SPMC_TLR);
    tester.pins(1'b1, 1'b1);
    user_tdo_oe_i <= 1'b1;
    user_tdo_i <= 1'b1;
    user_tck_oe_i <= 1'b1;
    user_tck_i <= 1'b1;
    user_tdi_oe_i <= 1'b1;
    user_tdi_i <= 1'b1;
    tdo_pin_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    chk_bit(tms_pullup_o | tdi_pullup_o, 1'b0);
    chk_bit(user_tdi_o, 1'b1);
    chk_bit(user_tdo_o & !scan_tdi_o, 1'b1);
    chk_bit(tdo_pin_oe_o & tdo_pin_o, 1'b1);
    chk_bit(tck_pin_oe_o & tck_pin_o & tdi_pin_oe_o & tdi_pin_o, 1'b1);
    chk_bit(trst_pin_oe_o, 1'b0);
    base_tck = user_tck_highs;
    base_rise = rise_pulses;
    base_fall = fall_pulses;
    tester.step(1'b1);
    repeat (4) @(posedge ref_clk_i);
    chk_bit(user_tck_highs - base_tck == 4, 1'b1);
    chk_bit(rise_pulses == base_rise && fall_pulses == base_fall, 1'b1);
    chk_state(tap_state_o, spmc_pkg::SPMC_TLR);
    tester.step(1'b0);
    chk_state(tap_state_o, spmc_pkg::SPMC_RTI);
    chk_bit(scan_owns_o, 1'b1);
    chk_bit(user_tdi_o | user_tdo_o | tdo_pin_oe_o | tck_pin_oe_o | tdi_pin_oe_o, 1'b0);
    tester.step(1'b1);
    tester.step(1'b0);
    tester.step(1'b0);
    chk_state(tap_state_o, spmc_pkg::SPMC_SH_DR);
    @(posedge ref_clk_i);
    scan_tdo_i <= 1'b1;
    user_tdo_i <= 1'b0;
    tester.step(1'b0);
    repeat (4) @(posedge ref_clk_i);
    chk_bit(tdo_pin_oe_o & tdo_pin_o, 1'b1);
    repeat (4) tester.step(1'b1);
    chk_bit(tap_state_o == spmc_pkg::SPMC_TLR, 1'b0);
    tester.step(1'b1);
    chk_state(tap_state_o, spmc_pkg::SPMC_TLR);
    repeat (2) @(posedge ref_clk_i);
    chk_bit(!scan_owns_o & user_tdi_o, 1'b1);
    @(posedge ref_clk_i);
    user_trst_used_i <= 1'b1;
    user_trst_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    chk_bit(trst_pin_oe_o & trst_pin_o & user_trst_o, 1'b1);
    @(posedge ref_clk_i);
    user_trst_oe_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk_bit(trst_pin_oe_o, 1'b0);
  endtask
  initial begin
    reset_i = 1'b1;
    {cfg_dedicated_i, cfg_trst_reserved_i, tdo_pin_i, user_tck_i, user_tck_oe_i} = 5'h00;
    {user_tdi_i, user_tdi_oe_i, user_tdo_i, user_tdo_oe_i, user_trst_used_i} = 5'h00;
    {user_trst_i, scan_tdo_i, user_trst_oe_i} = 3'h1;
    sc_ded;
    sc_flex;
    give_verdict;
  end
  // The whole run needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    failures++;
    give_verdict;
  end
endmodule
`default_nettype wire
